// File: core/nvc_pkg.sv
// Package for the nonvolatile static memory host controller
package nvc_pkg;
	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int CMD_ADDR_W = 14;
	localparam int SEQ_LEN = 6;
	// ----------------------------------------
	// Timing (ns unless stated), clock 4 ns
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int CYCLE_TIME_NS = 45;
	localparam int SELECT_TO_END_NS = 30;
	localparam int DATA_SETUP_NS = 15;
	localparam int ADDR_HOLD_NS = 1;
	localparam int OUTPUT_OFF_NS = 15;
	localparam int SAVE_REQUEST_PULSE_NS = 15;
	localparam int SAVE_DURATION_US = 15000;
	localparam int RESTORE_DURATION_US = 50;
	localparam int SEQUENCE_ACTION_TIME_US = 70;
	localparam int POWERUP_RESTORE_MS = 20;
	// Least times round up
	localparam int CYCLE_CLKS = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CLKS = (SELECT_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_SETUP_CLKS = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CLKS = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OFF_CLKS = (OUTPUT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CLKS = (SAVE_REQUEST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Wait for busy truncates; the durations are whole clock multiples, so host does not come early
	localparam int SAVE_WAIT_CLKS = SAVE_DURATION_US * 1000 / CLK_PERIOD_NS;
	localparam int RESTORE_WAIT_CLKS = RESTORE_DURATION_US * 1000 / CLK_PERIOD_NS;
	localparam int ACTION_WAIT_CLKS = SEQUENCE_ACTION_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int POWERUP_WAIT_CLKS = POWERUP_RESTORE_MS * 1000000 / CLK_PERIOD_NS;
	// ----------------------------------------
	// Command sequence addresses
	// ----------------------------------------
	localparam logic [CMD_ADDR_W-1:0] SEQ_A0 = 14'h0e38;
	localparam logic [CMD_ADDR_W-1:0] SEQ_A1 = 14'h31c7;
	localparam logic [CMD_ADDR_W-1:0] SEQ_A2 = 14'h03e0;
	localparam logic [CMD_ADDR_W-1:0] SEQ_A3 = 14'h3c1f;
	localparam logic [CMD_ADDR_W-1:0] SEQ_A4 = 14'h303f;
	localparam logic [CMD_ADDR_W-1:0] SEQ_SAVE = 14'h0fc0;
	localparam logic [CMD_ADDR_W-1:0] SEQ_RESTORE = 14'h0c63;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		NVC_OP_READ = 3'h0,
		NVC_OP_WRITE = 3'h1,
		NVC_OP_SW_SAVE = 3'h2,
		NVC_OP_SW_RESTORE = 3'h3,
		NVC_OP_HW_SAVE = 3'h4
	} nvc_op_type;
	typedef struct packed {
		nvc_op_type op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} nvc_req_type;
	typedef struct packed {
		logic chip_select_n;
		logic write_strobe_n;
		logic output_drive_n;
		logic [ADDR_W-1:0] addr;
	} nvc_pins_type;
endpackage : nvc_pkg

// File: core/nvc_host.sv
// Host controller driving the nonvolatile static memory pins
`timescale 1ns/1ns
module nvc_host #(
	parameter int SAVE_WAIT = nvc_pkg::SAVE_WAIT_CLKS,
	parameter int RESTORE_WAIT = nvc_pkg::RESTORE_WAIT_CLKS,
	parameter int ACTION_WAIT = nvc_pkg::ACTION_WAIT_CLKS,
	parameter int POWERUP_WAIT = nvc_pkg::POWERUP_WAIT_CLKS
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Request side
	input wire logic req_valid_i,
	input wire nvc_pkg::nvc_req_type req_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [nvc_pkg::DATA_W-1:0] rsp_data_o,
	output logic busy_o,
	// Memory pins
	output nvc_pkg::nvc_pins_type pins_o,
	input wire logic [nvc_pkg::DATA_W-1:0] data_lines_i,
	output logic [nvc_pkg::DATA_W-1:0] data_lines_o,
	output logic data_lines_oe_n_o,
	input wire logic store_busy_n_i,
	output logic store_busy_n_o,
	output logic store_busy_n_oe_n_o
);
	import nvc_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [DATA_W-1:0] data_meta_q, data_sync_q;
	logic busy_meta_q, busy_sync_q;
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			data_meta_q <= '0;
			data_sync_q <= '0;
			busy_meta_q <= 1'b1;
			busy_sync_q <= 1'b1;
		end else begin
			data_meta_q <= data_lines_i;
			data_sync_q <= data_meta_q;
			busy_meta_q <= store_busy_n_i;
			busy_sync_q <= busy_meta_q;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_POWERUP = 4'h0,
		ST_IDLE = 4'h1,
		ST_SETUP = 4'h2,
		ST_STROBE = 4'h3,
		ST_HOLD = 4'h4,
		ST_GAP = 4'h5,
		ST_HW_PULSE = 4'h6,
		ST_WAIT_NV = 4'h7,
		ST_WAIT_BUSY = 4'h8
	} nvc_state_type;

	localparam int CNT_W = 32;
	nvc_state_type state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] nv_wait_q;
	nvc_req_type cur_q;
	logic [2:0] step_q;
	logic is_seq_q;
	logic [DATA_W-1:0] rdata_q;
	logic rsp_q;

	logic last_step;
	assign last_step = (step_q == 3'(SEQ_LEN - 1));

	// Address of the current sequence step; top bit kept low
	function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] s, input nvc_op_type op);
		logic [CMD_ADDR_W-1:0] a;
		a = SEQ_A0;
		unique case (s)
			3'h0: a = SEQ_A0;
			3'h1: a = SEQ_A1;
			3'h2: a = SEQ_A2;
			3'h3: a = SEQ_A3;
			3'h4: a = SEQ_A4;
			default: a = (op == NVC_OP_SW_SAVE) ? SEQ_SAVE : SEQ_RESTORE;
		endcase
		return {1'b0, a};
	endfunction : seq_addr

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= ST_POWERUP;
			cnt_q <= '0;
			nv_wait_q <= '0;
			cur_q <= '0;
			step_q <= '0;
			is_seq_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_POWERUP: begin
					// Device restores itself after supply rise
					if (cnt_q >= CNT_W'(POWERUP_WAIT - 1)) begin
						state_q <= ST_IDLE;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_IDLE: begin
					cnt_q <= '0;
					step_q <= '0;
					if (!busy_sync_q) begin
						// Save under way by another party; accesses would be lost
						state_q <= ST_WAIT_BUSY;
					end else if (req_valid_i) begin
						cur_q <= req_i;
						unique case (req_i.op)
							NVC_OP_HW_SAVE: state_q <= ST_HW_PULSE;
							NVC_OP_SW_SAVE, NVC_OP_SW_RESTORE: begin
								is_seq_q <= 1'b1;
								cur_q.addr <= seq_addr(3'h0, req_i.op);
								state_q <= ST_SETUP;
							end
							default: begin
								is_seq_q <= 1'b0;
								state_q <= ST_SETUP;
							end
						endcase
					end
				end
				ST_SETUP: begin
					// Address settles with strobes high
					state_q <= ST_STROBE;
					cnt_q <= '0;
				end
				ST_STROBE: begin
					if (cnt_q >= CNT_W'(STROBE_CLKS - 1)) begin
						state_q <= ST_HOLD;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_HOLD: begin
					if (cnt_q >= CNT_W'(HOLD_CLKS - 1)) begin
						state_q <= ST_GAP;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_GAP: begin
					// Pads the cycle to full cycle time, and lets data float
					if (cnt_q >= CNT_W'(CYCLE_CLKS - STROBE_CLKS - HOLD_CLKS - 2)) begin
						cnt_q <= '0;
						if (is_seq_q && !last_step) begin
							step_q <= step_q + 1'b1;
							cur_q.addr <= seq_addr(step_q + 1'b1, cur_q.op);
							state_q <= ST_SETUP;
						end else if (is_seq_q) begin
							nv_wait_q <= (cur_q.op == NVC_OP_SW_SAVE)
								? CNT_W'(ACTION_WAIT + SAVE_WAIT)
								: CNT_W'(ACTION_WAIT + RESTORE_WAIT);
							state_q <= ST_WAIT_NV;
						end else begin
							state_q <= ST_IDLE;
						end
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_HW_PULSE: begin
					if (cnt_q >= CNT_W'(PULSE_CLKS)) begin
						nv_wait_q <= CNT_W'(ACTION_WAIT + SAVE_WAIT);
						cnt_q <= '0;
						state_q <= ST_WAIT_NV;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_WAIT_NV: begin
					// Worst-case wait; a skipped save only costs time
					if (cnt_q >= nv_wait_q) begin
						cnt_q <= '0;
						state_q <= ST_WAIT_BUSY;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_WAIT_BUSY: begin
					if (busy_sync_q) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Read capture and response
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_q <= '0;
			rsp_q <= 1'b0;
		end else begin
			rsp_q <= 1'b0;
			// Sample late in strobe, after two-flop delay of the bus
			if (state_q == ST_HOLD && cur_q.op == NVC_OP_READ) begin
				rdata_q <= data_sync_q;
				rsp_q <= 1'b1;
			end else if (state_q == ST_WAIT_BUSY && busy_sync_q && cur_q.op != NVC_OP_READ
				&& cur_q.op != NVC_OP_WRITE) begin
				rsp_q <= 1'b1;
			end else if (state_q == ST_GAP && cnt_q == '0 && cur_q.op == NVC_OP_WRITE) begin
				rsp_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	logic strobe_on, is_write;
	assign strobe_on = (state_q == ST_STROBE);
	assign is_write = (cur_q.op == NVC_OP_WRITE) && !is_seq_q;
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			pins_o <= '{chip_select_n: 1'b1, write_strobe_n: 1'b1,
				output_drive_n: 1'b1, addr: '0};
			data_lines_o <= '0;
			data_lines_oe_n_o <= 1'b1;
			store_busy_n_oe_n_o <= 1'b1;
		end else begin
			// Select high outside the strobe keeps device idle
			pins_o.chip_select_n <= !((state_q == ST_SETUP) || strobe_on) ||
				(state_q == ST_SETUP);
			// Write strobe low only inside select, so device never drives
			pins_o.write_strobe_n <= !(strobe_on && is_write);
			pins_o.output_drive_n <= !(strobe_on && !is_write);
			if (state_q == ST_SETUP || state_q == ST_IDLE) begin
				pins_o.addr <= cur_q.addr;
			end
			data_lines_o <= cur_q.wdata;
			// Drive data only after device released it
			data_lines_oe_n_o <= !(is_write && strobe_on
				&& cnt_q >= CNT_W'(OFF_CLKS - DATA_SETUP_CLKS + 1));
			store_busy_n_oe_n_o <= !(state_q == ST_HW_PULSE);
		end
	end

	assign store_busy_n_o = 1'b0;
	assign req_ready_o = (state_q == ST_IDLE) && busy_sync_q;
	assign rsp_valid_o = rsp_q;
	assign rsp_data_o = rdata_q;
	assign busy_o = (state_q != ST_IDLE);
endmodule : nvc_host

// File: sim/nvc_host_properties.sv
// Pin timing checks on the host controller
`timescale 1ns/1ns
module nvc_host_properties (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Observed ports
	input wire logic req_ready_o,
	input wire nvc_pkg::nvc_pins_type pins_o,
	input wire logic [nvc_pkg::DATA_W-1:0] data_lines_o,
	input wire logic data_lines_oe_n_o,
	input wire logic store_busy_n_i,
	input wire logic store_busy_n_oe_n_o
);
	import nvc_pkg::*;
	logic [3:0] gap_q;
	// Cycles since the last select fall, saturating
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			gap_q <= 4'hf;
		end else if ($fell(pins_o.chip_select_n)) begin
			gap_q <= 4'h0;
		end else if (gap_q != 4'hf) begin
			gap_q <= gap_q + 4'h1;
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	addr_write_stable_a: assert property (!pins_o.chip_select_n && !pins_o.write_strobe_n &&
		$past(pins_o.chip_select_n) == 1'b0 && $past(pins_o.write_strobe_n) == 1'b0
		|-> $stable(pins_o.addr)) else $error("address moved in write");
	addr_hold_a: assert property ($rose(pins_o.chip_select_n) |-> $stable(pins_o.addr))
		else $error("address not held at deselect");
	write_width_a: assert property ($fell(pins_o.write_strobe_n) |->
		(!pins_o.write_strobe_n && !pins_o.chip_select_n)[*8]) else $error("write too short");
	data_setup_a: assert property ($rose(pins_o.write_strobe_n) |->
		$past(data_lines_oe_n_o, 1) == 1'b0 && $past(data_lines_oe_n_o, 4) == 1'b0 &&
		$past(data_lines_o, 4) == $past(data_lines_o, 1)) else $error("data setup short");
	drive_in_write_a: assert property (!data_lines_oe_n_o |->
		!pins_o.write_strobe_n && !pins_o.chip_select_n) else $error("data driven off write");
	read_strobes_a: assert property (!pins_o.output_drive_n |->
		pins_o.write_strobe_n && !pins_o.chip_select_n) else $error("bad read strobes");
	cycle_gap_a: assert property ($fell(pins_o.chip_select_n) |-> gap_q >= 4'hb)
		else $error("cycles too close");
	save_pulse_a: assert property ($fell(store_busy_n_oe_n_o) |->
		(!store_busy_n_oe_n_o)[*4]) else $error("save request too short");
	busy_refuse_a: assert property ((!store_busy_n_i)[*3] |-> !req_ready_o)
		else $error("request taken while busy");
endmodule : nvc_host_properties
bind nvc_host nvc_host_properties u_props (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
	.req_ready_o(req_ready_o), .pins_o(pins_o), .data_lines_o(data_lines_o),
	.data_lines_oe_n_o(data_lines_oe_n_o), .store_busy_n_i(store_busy_n_i),
	.store_busy_n_oe_n_o(store_busy_n_oe_n_o));

// File: sim/nvc_mem_model.sv
// Behavioural model of the nonvolatile static memory
`timescale 1ns/1ns
module nvc_mem_model (
	// Clock, reset and pace
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic slow_i,
	// Host side
	input wire nvc_pkg::nvc_pins_type pins_i,
	input wire logic [nvc_pkg::DATA_W-1:0] host_data_i,
	input wire logic host_data_oe_n_i,
	input wire logic host_busy_oe_n_i,
	// Resolved wires
	output logic [nvc_pkg::DATA_W-1:0] data_wire_o,
	output logic busy_wire_n_o
);
	import nvc_pkg::*;
	localparam logic [CMD_ADDR_W-1:0] SEQ [0:4] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
	bit [7:0] mem [0:32767];
	bit [7:0] shadow [0:32767];
	nvc_pins_type p_q;
	logic [7:0] dq_q;
	logic dev_oe, pull_q, dirty_q;
	int step_q, lock_q;
	// Undriven data shows a changing pattern, busy has a weak pull-up
	assign dev_oe = !pins_i.chip_select_n && pins_i.write_strobe_n &&
		!pins_i.output_drive_n && lock_q == 0;
	assign data_wire_o = !host_data_oe_n_i ? host_data_i : dev_oe ? mem[pins_i.addr] : ~dq_q;
	assign busy_wire_n_o = host_busy_oe_n_i && !pull_q;
	always @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			p_q <= '1;
			dq_q <= 8'h00;
			step_q <= 0;
			lock_q <= 5;
			pull_q <= 1'b0;
			dirty_q <= 1'b0;
		end else begin
			p_q <= pins_i;
			dq_q <= data_wire_o;
			if (lock_q != 0) begin
				lock_q <= lock_q - 1;
				if (lock_q == 1) begin
					pull_q <= 1'b0;
					dirty_q <= 1'b0;
				end
			end else if (!busy_wire_n_o) begin
				if (dirty_q) begin
					shadow = mem;
					pull_q <= 1'b1;
					lock_q <= slow_i ? 60 : 10;
				end
			end else begin
				if (!p_q.chip_select_n && !p_q.write_strobe_n &&
					(pins_i.chip_select_n || pins_i.write_strobe_n)) begin
					mem[p_q.addr] = dq_q;
					dirty_q <= 1'b1;
				end
				if (p_q.chip_select_n && !pins_i.chip_select_n) begin
					if (!pins_i.write_strobe_n) begin
						step_q <= 0;
					end else if (step_q == 5 && pins_i.addr[13:0] == SEQ_SAVE) begin
						shadow = mem;
						pull_q <= 1'b1;
						lock_q <= slow_i ? 60 : 10;
						step_q <= 0;
					end else if (step_q == 5 && pins_i.addr[13:0] == SEQ_RESTORE) begin
						mem = shadow;
						lock_q <= slow_i ? 35 : 10;
						step_q <= 0;
					end else if (step_q < 5 && pins_i.addr[13:0] == SEQ[step_q]) begin
						step_q <= step_q + 1;
					end else begin
						step_q <= (pins_i.addr[13:0] == SEQ_A0) ? 1 : 0;
					end
				end
			end
		end
	end
endmodule : nvc_mem_model

// File: sim/nvc_host_test.sv
// Self-checking testbench for the host controller
`timescale 1ns/1ns
module nvc_host_test;
	import nvc_pkg::*;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic req_valid = 1'b0;
	nvc_req_type req = '0;
	logic slow = 1'b0;
	logic req_ready, rsp_valid, busy, dq_oe_n, sb_oe_n, sb_wire;
	logic [DATA_W-1:0] rsp_data, dq_o, dq_wire;
	nvc_pins_type pins;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	bit [7:0] m_mem [0:32767];
	bit [7:0] m_shadow [0:32767];
	bit m_dirty = 1'b0;
	logic [31:0] rng = 32'h8063;
	always #2 clk_sys_i = ~clk_sys_i;
	nvc_host #(.SAVE_WAIT(20), .RESTORE_WAIT(20), .ACTION_WAIT(20), .POWERUP_WAIT(20)) u_dut (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_valid_i(req_valid), .req_i(req),
		.req_ready_o(req_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .busy_o(busy),
		.pins_o(pins), .data_lines_i(dq_wire), .data_lines_o(dq_o), .data_lines_oe_n_o(dq_oe_n),
		.store_busy_n_i(sb_wire), .store_busy_n_o(), .store_busy_n_oe_n_o(sb_oe_n));
	nvc_mem_model u_mem (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .slow_i(slow), .pins_i(pins),
		.host_data_i(dq_o), .host_data_oe_n_i(dq_oe_n), .host_busy_oe_n_i(sb_oe_n),
		.data_wire_o(dq_wire), .busy_wire_n_o(sb_wire));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	task automatic report_and_stop();
		if (errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	// Hold the request until taken, then wait for its answer
	task automatic do_op(input nvc_op_type op, input logic [14:0] ad, input logic [7:0] wd);
		req_valid <= 1'b1;
		req <= '{op: op, addr: ad, wdata: wd};
		do @(posedge clk_sys_i); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		@(posedge clk_sys_i);
		checked++;
		if (busy !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: busy low after take", $time);
		end
		while (rsp_valid !== 1'b1) @(posedge clk_sys_i);
	endtask : do_op
	task automatic wr(input logic [14:0] ad, input logic [7:0] wd);
		do_op(NVC_OP_WRITE, ad, wd);
		m_mem[ad] = wd;
		m_dirty = 1'b1;
	endtask : wr
	task automatic rd(input logic [14:0] ad);
		do_op(NVC_OP_READ, ad, 8'h00);
		checked++;
		if (rsp_data !== m_mem[ad]) begin
			errors++;
			$display("wrong value at %0t: read %h got %h", $time, ad, rsp_data);
		end
	endtask : rd
	task automatic nv(input nvc_op_type op);
		do_op(op, 15'h0000, 8'h00);
		if (op == NVC_OP_SW_RESTORE)
			m_mem = m_shadow;
		else if (op == NVC_OP_SW_SAVE || m_dirty)
			m_shadow = m_mem;
		m_dirty = 1'b0;
	endtask : nv
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (20) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		// Power-up wait of 20 cycles, as given to the instance
		repeat (20) @(posedge clk_sys_i);
		checked++;
		if (req_ready !== 1'b0) begin
			errors++;
			$display("wrong value at %0t: ready before power-up wait", $time);
		end
		for (int i = 0; i < 8; i++) begin
			rng = xorshift(rng);
			wr(rng[14:0], rng[22:15]);
			rd(rng[14:0]);
			rd(rng[14:0] ^ 15'h0001);
		end
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			wr(15'h4e38, 8'h5a ^ s[7:0]);
			nv(NVC_OP_SW_SAVE);
			wr(15'h4e38, 8'ha5);
			rd(15'h4e38);
			nv(NVC_OP_SW_RESTORE);
			rd(15'h4e38);
		end
		wr(15'h0123, 8'h3c);
		nv(NVC_OP_HW_SAVE);
		wr(15'h0123, 8'hc3);
		nv(NVC_OP_SW_RESTORE);
		rd(15'h0123);
		slow <= 1'b0;
		nv(NVC_OP_HW_SAVE);
		wr(15'h0123, 8'h77);
		nv(NVC_OP_SW_RESTORE);
		rd(15'h0123);
		report_and_stop();
	end
endmodule : nvc_host_test
